//--- common/cantsf_pkg.sv
// package: constants and types of the can timestamp and filter block
package cantsf_pkg;
	localparam logic [7:0] ADDR_TEST = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_TIMESTAMP_CONFIG_REG = 8'h08;
	localparam logic [7:0] ADDR_TIMESTAMP_VALUE_REG = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_NEWDATA = 8'h14;
	localparam logic [7:0] ADDR_EXT_ID_AND_MASK = 8'h18;
	localparam logic [7:0] ADDR_PUTIDX = 8'h1C;
	localparam logic [7:0] ADDR_FILT = 8'h40;
	localparam int FILT_SH = 3;
	localparam int TEST_LB = 0;
	localparam int TEST_OVR = 1;
	localparam int TEST_OVR_VAL = 2;
	localparam int TEST_RX_PIN = 3;
	localparam int CFG_MON = 0;
	localparam int ST_TSW = 0;
	localparam int ST_HPM = 1;
	localparam int ST_ELO = 22;
	localparam int ST_EP = 23;
	localparam int ST_EW = 24;
	localparam int FE_HI = 29;
	localparam int FE_EXT = 31;
	localparam int FE_EVT = 5;
	localparam int BUF_W = 5;
	localparam int PUT1_LSB = 8;
	localparam int STD_ID_W = 11;
	localparam int ID_W = 29;
	localparam int TS_W = 16;
	localparam int PRESC_W = 4;
	localparam int WORD_W = 5;
	localparam logic [28:0] EXT_ID_AND_MASK_RESET = 29'h1FFFFFFF;
	localparam logic RECESSIVE = 1'h1;
	localparam logic [1:0] TGT_BUF = 2'h0;
	localparam logic [1:0] TGT_FIFO0 = 2'h1;
	localparam logic [1:0] TGT_FIFO1 = 2'h2;
	localparam logic [4:0] WORD_ID = 5'h00;
	localparam logic [4:0] WORD_TS = 5'h01;
	localparam logic [4:0] WORD_DATA = 5'h02;
	typedef enum logic [2:0] {ACT_OFF, ACT_FIFO0, ACT_FIFO1, ACT_REJECT,
		ACT_HPM, ACT_HPM_FIFO0, ACT_HPM_FIFO1, ACT_RXBUF} cantsf_action_type;
	typedef enum logic [1:0] {FT_RANGE, FT_DUAL, FT_CLASSIC,
		FT_RANGE_RAW} cantsf_ftype_type;
	typedef enum logic [1:0] {S_IDLE, S_HDR_ID, S_HDR_TS,
		S_DATA} cantsf_state_type;
endpackage

//--- rtl/cantsf_top.sv
// receive side of a can controller: test modes, timestamp, filtering
// Notes on behaviour
// R1: loopback_enable set: own transmitted frames are received and filtered.
// R2: in either loop-back mode acknowledge errors are ignored.
// R3: external loop-back feeds tx back to rx, pin ignored, tx still shown.
// R4: loopback_enable plus bus_monitor_mode: rx pin cut, tx pin recessive.
// R5: tx_pin_override and rx pin readback pass a synchroniser delay.
// R6: software uses test modes only for production or self test.
// R7: a 16-bit wrapping timestamp counter is readable as timestamp_count.
// R8: the counter steps once every 1 to 16 bit times per prescale.
// R9: any write to timestamp_value_reg clears the counter.
// R10: counter wrap sets timestamp_wrap_flag.
// R11: the counter is captured at frame start into the stored element.
// R12: matching element stores, stores with event, rejects, or sets priority.
// R13: filtering starts after the identifier; storage goes in 32-bit words.
// R14: an errored frame never sets the buffer's new_data flag.
// R15: an errored frame leaves the fifo put index unchanged.
// R16: the received identifier is stored unmodified.
// R17: range element matches identifiers between its two bounds.
// R18: extended range type 00 applies ext_id_and_mask, type 11 does not.
// R19: dual-id element matches either identifier, equal ids match one.
// R20: classic filter: id1 is reference, id2 mask, zero bits ignored.
// R21: all-ones mask matches one id, all-zeros mask matches every id.
// R22: warning and passive changes and log overflow set status flags.
// R23: elements are checked in order, the first match decides.
// R24: extended_id_flag selects 11-bit or 29-bit identifier and filter set.
// R25: update sets new_data; writing 1 clears it, writing 0 does nothing.
`timescale 1ns/100ps
module cantsf_top #(
	parameter int NUM_FILTERS = 4,
	parameter int PUT_W = 6
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// can pins
	input wire logic can_rx_pin,
	output logic can_tx_pin,
	// protocol engine
	input wire logic engine_tx,
	output logic engine_rx,
	input wire logic ack_err,
	output logic engine_ack_err,
	input wire logic bit_tick,
	input wire logic sof,
	input wire logic id_done,
	input wire logic [28:0] rx_id,
	input wire logic rx_xtd,
	input wire logic word_valid,
	input wire logic [31:0] word_data,
	input wire logic frame_ok,
	input wire logic frame_err,
	input wire logic err_warning,
	input wire logic err_passive,
	input wire logic log_overflow,
	// message store write port
	output logic wr_valid,
	output logic [1:0] wr_target,
	output logic [PUT_W-1:0] wr_index,
	output logic [4:0] wr_word,
	output logic [31:0] wr_data,
	output logic filter_event,
	output logic [15:0] frame_timestamp
);
	typedef struct packed {
		logic lb;
		logic ovr;
		logic ovr_val;
		logic mon;
		logic [1:0] ovr_p1;
		logic [1:0] ovr_p2;
		logic rx_s1;
		logic rx_s2;
		logic [cantsf_pkg::PRESC_W-1:0] timestamp_config_reg;
		logic [cantsf_pkg::PRESC_W-1:0] pc;
		logic [cantsf_pkg::TS_W-1:0] ts;
		logic [cantsf_pkg::TS_W-1:0] cap_ts;
		logic [31:0] status;
		logic [31:0] new_data;
		logic [28:0] ext_id_and_mask;
		logic [NUM_FILTERS-1:0][31:0] fa;
		logic [NUM_FILTERS-1:0][31:0] fb;
		logic [PUT_W-1:0] put0;
		logic [PUT_W-1:0] put1;
		logic ew_prev;
		logic ep_prev;
		cantsf_pkg::cantsf_state_type state;
		logic [1:0] tgt;
		logic [PUT_W-1:0] idx;
		logic evt;
		logic [4:0] word;
		logic [28:0] id;
		logic extended_id_flag;
		logic wr_pend;
		logic rd_pend;
		logic [7:0] addr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic engine_rx;
		logic ack_err;
		logic can_tx;
		logic wr_valid;
		logic [1:0] wr_target;
		logic [PUT_W-1:0] wr_index;
		logic [4:0] wr_word;
		logic [31:0] wr_data;
		logic filter_event;
	} cantsf_regs_type;

	cantsf_regs_type q;
	cantsf_regs_type n;
	logic acc;
	logic ts_wr;
	logic hit;
	logic store;
	logic emit;
	logic [31:0] edata;
	logic [31:0] rd;
	int fsel;
	cantsf_pkg::cantsf_action_type act;

	// one filter element against the received identifier
	function automatic logic id_match(input logic [31:0] a,
			input logic [31:0] b, input logic [28:0] id, input logic extended_id_flag,
			input logic [28:0] xmask);
		logic [28:0] w;
		logic [28:0] id1;
		logic [28:0] id2;
		logic [28:0] m;
		cantsf_pkg::cantsf_action_type ac;
		cantsf_pkg::cantsf_ftype_type ft;
		w = extended_id_flag ? '1 : 29'((1 << cantsf_pkg::STD_ID_W) - 1); // [R24]
		id1 = a[28:0] & w;
		id2 = b[28:0] & w;
		m = id & w;
		ac = cantsf_pkg::cantsf_action_type'(a[31:cantsf_pkg::FE_HI]);
		ft = cantsf_pkg::cantsf_ftype_type'(b[30:cantsf_pkg::FE_HI]);
		id_match = 1'b0;
		if (ac != cantsf_pkg::ACT_OFF && b[cantsf_pkg::FE_EXT] == extended_id_flag) begin
			if (ac == cantsf_pkg::ACT_RXBUF) begin
				// id2 carries buffer index here, so only exact match
				id_match = (m == id1);
			end else begin
				case (ft)
					cantsf_pkg::FT_RANGE: begin
						if (extended_id_flag) begin
							m = m & xmask; // [R18]
						end
						id_match = (id1 <= m) && (m <= id2); // [R17]
					end
					cantsf_pkg::FT_RANGE_RAW: begin
						id_match = (id1 <= m) && (m <= id2); // [R18]
					end
					cantsf_pkg::FT_DUAL: begin
						id_match = (m == id1) || (m == id2); // [R19]
					end
					default: begin
						id_match = ((m ^ id1) & id2) == '0; // [R20] [R21]
					end
				endcase
			end
		end
	endfunction

	function automatic logic in_filt(input logic [7:0] ad);
		in_filt = int'(ad) >= int'(cantsf_pkg::ADDR_FILT) &&
			int'(ad) < int'(cantsf_pkg::ADDR_FILT) +
			(NUM_FILTERS << cantsf_pkg::FILT_SH);
	endfunction

	function automatic int filt_idx(input logic [7:0] ad);
		filt_idx = (int'(ad) - int'(cantsf_pkg::ADDR_FILT)) >>
			cantsf_pkg::FILT_SH;
	endfunction

	always_comb begin
		n = q;
		acc = hsel && htrans[1] && hready;
		ts_wr = q.wr_pend && (q.addr == cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG); // [R9]
		n.wr_valid = 1'b0;
		n.filter_event = 1'b0;
		emit = 1'b0;
		edata = '0;
		rd = '0;
		// lowest index walked last, so the first element wins
		hit = 1'b0;
		fsel = 0;
		for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
			if (id_match(q.fa[i], q.fb[i], rx_id, rx_xtd, q.ext_id_and_mask)) begin
				hit = 1'b1; // [R23]
				fsel = i;
			end
		end
		act = cantsf_pkg::cantsf_action_type'(
			q.fa[fsel][31:cantsf_pkg::FE_HI]);
		store = hit && act != cantsf_pkg::ACT_REJECT &&
			act != cantsf_pkg::ACT_HPM; // [R12]

		// bus: register writes land in the data phase
		if (q.wr_pend) begin
			case (q.addr)
				cantsf_pkg::ADDR_TEST: begin
					n.lb = hwdata[cantsf_pkg::TEST_LB];
					n.ovr = hwdata[cantsf_pkg::TEST_OVR];
					n.ovr_val = hwdata[cantsf_pkg::TEST_OVR_VAL];
				end
				cantsf_pkg::ADDR_CONFIG: begin
					n.mon = hwdata[cantsf_pkg::CFG_MON];
				end
				cantsf_pkg::ADDR_TIMESTAMP_CONFIG_REG: begin
					n.timestamp_config_reg = hwdata[cantsf_pkg::PRESC_W-1:0];
				end
				cantsf_pkg::ADDR_STATUS: begin
					n.status = q.status & ~hwdata;
				end
				cantsf_pkg::ADDR_NEWDATA: begin
					n.new_data = q.new_data & ~hwdata; // [R25]
				end
				cantsf_pkg::ADDR_EXT_ID_AND_MASK: begin
					n.ext_id_and_mask = hwdata[28:0];
				end
				default: begin
					if (in_filt(q.addr) && q.addr[2]) begin
						n.fb[filt_idx(q.addr)] = hwdata;
					end else if (in_filt(q.addr)) begin
						n.fa[filt_idx(q.addr)] = hwdata;
					end
				end
			endcase
		end

		// bus: one wait state per read so a preceding write is seen
		n.wr_pend = acc && hwrite;
		if (acc) begin
			n.addr = haddr[7:0];
		end
		if (acc && !hwrite) begin
			n.rd_pend = 1'b1;
			n.hreadyout = 1'b0;
		end
		if (q.rd_pend) begin
			case (q.addr)
				cantsf_pkg::ADDR_TEST: begin
					rd[cantsf_pkg::TEST_LB] = q.lb;
					rd[cantsf_pkg::TEST_OVR] = q.ovr;
					rd[cantsf_pkg::TEST_OVR_VAL] = q.ovr_val;
					rd[cantsf_pkg::TEST_RX_PIN] = q.rx_s2; // [R5]
				end
				cantsf_pkg::ADDR_CONFIG: rd[cantsf_pkg::CFG_MON] = q.mon;
				cantsf_pkg::ADDR_TIMESTAMP_CONFIG_REG: rd[cantsf_pkg::PRESC_W-1:0] = q.timestamp_config_reg;
				cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG: rd[cantsf_pkg::TS_W-1:0] = q.ts; // [R7]
				cantsf_pkg::ADDR_STATUS: rd = q.status;
				cantsf_pkg::ADDR_NEWDATA: rd = q.new_data;
				cantsf_pkg::ADDR_EXT_ID_AND_MASK: rd[28:0] = q.ext_id_and_mask;
				cantsf_pkg::ADDR_PUTIDX: begin
					rd[PUT_W-1:0] = q.put0;
					rd[cantsf_pkg::PUT1_LSB +: PUT_W] = q.put1;
				end
				default: begin
					if (in_filt(q.addr) && q.addr[2]) begin
						rd = q.fb[filt_idx(q.addr)];
					end else if (in_filt(q.addr)) begin
						rd = q.fa[filt_idx(q.addr)];
					end
				end
			endcase
			n.hrdata = rd;
			n.hreadyout = 1'b1;
			n.rd_pend = 1'b0;
		end

		// pins: override and readback go through two stages
		n.ovr_p1 = {q.ovr, q.ovr_val}; // [R5]
		n.ovr_p2 = q.ovr_p1;
		n.rx_s1 = can_rx_pin;
		n.rx_s2 = q.rx_s1;
		n.engine_rx = q.lb ? engine_tx : can_rx_pin; // [R1] [R3]
		n.ack_err = ack_err && !q.lb; // [R2]
		if (q.lb && q.mon) begin
			n.can_tx = cantsf_pkg::RECESSIVE; // [R4]
		end else if (q.ovr_p2[1]) begin
			n.can_tx = q.ovr_p2[0];
		end else begin
			n.can_tx = engine_tx; // [R3]
		end

		// timestamp; a register write beats the tick
		if (bit_tick && q.pc == q.timestamp_config_reg) begin
			n.pc = '0;
			n.ts = q.ts + 16'h0001; // [R7] [R8]
			if (q.ts == '1) begin
				n.status[cantsf_pkg::ST_TSW] = 1'b1; // [R10]
			end
		end else if (bit_tick) begin
			n.pc = q.pc + 4'h1; // [R8]
		end
		if (ts_wr) begin
			n.ts = '0; // [R9]
			n.pc = '0;
		end
		if (sof) begin
			n.cap_ts = q.ts; // [R11]
		end

		// error state changes, set after the clear so set wins
		n.ew_prev = err_warning;
		n.ep_prev = err_passive;
		if (err_warning != q.ew_prev) begin
			n.status[cantsf_pkg::ST_EW] = 1'b1; // [R22]
		end
		if (err_passive != q.ep_prev) begin
			n.status[cantsf_pkg::ST_EP] = 1'b1; // [R22]
		end
		if (log_overflow) begin
			n.status[cantsf_pkg::ST_ELO] = 1'b1; // [R22]
		end

		// storage sequence: id word, timestamp word, then data
		case (q.state)
			cantsf_pkg::S_IDLE: begin
				n.state = cantsf_pkg::S_IDLE;
			end
			cantsf_pkg::S_HDR_ID: begin
				emit = 1'b1;
				edata = {2'h0, q.extended_id_flag, q.id}; // [R16]
				n.word = cantsf_pkg::WORD_ID;
				n.state = cantsf_pkg::S_HDR_TS;
			end
			cantsf_pkg::S_HDR_TS: begin
				emit = 1'b1;
				edata = {16'h0000, q.cap_ts}; // [R11]
				n.word = cantsf_pkg::WORD_TS;
				n.state = cantsf_pkg::S_DATA;
			end
			cantsf_pkg::S_DATA: begin
				if (word_valid) begin
					emit = 1'b1; // [R13]
					edata = word_data;
					n.word = q.word + 5'h01;
				end
				if (frame_err) begin
					n.state = cantsf_pkg::S_IDLE; // [R14] [R15]
				end else if (frame_ok) begin
					n.state = cantsf_pkg::S_IDLE;
					n.filter_event = q.evt; // [R12]
					case (q.tgt)
						cantsf_pkg::TGT_FIFO0: n.put0 = q.put0 + 1'b1;
						cantsf_pkg::TGT_FIFO1: n.put1 = q.put1 + 1'b1;
						default: n.new_data[q.idx[cantsf_pkg::BUF_W-1:0]] = 1'b1; // [R25]
					endcase
				end
			end
			default: n.state = cantsf_pkg::S_IDLE;
		endcase
		if (emit) begin
			n.wr_valid = 1'b1;
			n.wr_target = q.tgt;
			n.wr_index = q.idx;
			n.wr_word = (q.state == cantsf_pkg::S_DATA) ? q.word : n.word;
			n.wr_data = edata;
			if (q.state == cantsf_pkg::S_HDR_TS) begin
				n.word = cantsf_pkg::WORD_DATA;
			end
		end

		// filter decision once the identifier is complete
		if (id_done) begin
			n.state = store ? cantsf_pkg::S_HDR_ID : cantsf_pkg::S_IDLE; // [R13]
			n.id = rx_id;
			n.extended_id_flag = rx_xtd;
			n.evt = 1'b0;
			if (hit && (act == cantsf_pkg::ACT_HPM ||
					act == cantsf_pkg::ACT_HPM_FIFO0 ||
					act == cantsf_pkg::ACT_HPM_FIFO1)) begin
				n.status[cantsf_pkg::ST_HPM] = 1'b1; // [R12]
			end
			case (act)
				cantsf_pkg::ACT_FIFO0, cantsf_pkg::ACT_HPM_FIFO0: begin
					n.tgt = cantsf_pkg::TGT_FIFO0;
					n.idx = q.put0;
				end
				cantsf_pkg::ACT_FIFO1, cantsf_pkg::ACT_HPM_FIFO1: begin
					n.tgt = cantsf_pkg::TGT_FIFO1;
					n.idx = q.put1;
				end
				default: begin
					n.tgt = cantsf_pkg::TGT_BUF;
					n.idx = PUT_W'(q.fb[fsel][cantsf_pkg::BUF_W-1:0]);
					n.evt = q.fb[fsel][cantsf_pkg::FE_EVT];
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			q <= '0;
			q.state <= cantsf_pkg::S_IDLE;
			q.hreadyout <= 1'b1;
			q.ext_id_and_mask <= cantsf_pkg::EXT_ID_AND_MASK_RESET;
			q.can_tx <= cantsf_pkg::RECESSIVE;
			q.engine_rx <= cantsf_pkg::RECESSIVE;
		end else begin
			q <= n;
		end
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hreadyout;
	assign hresp = q.hresp;
	assign can_tx_pin = q.can_tx;
	assign engine_rx = q.engine_rx;
	assign engine_ack_err = q.ack_err;
	assign wr_valid = q.wr_valid;
	assign wr_target = q.wr_target;
	assign wr_index = q.wr_index;
	assign wr_word = q.wr_word;
	assign wr_data = q.wr_data;
	assign filter_event = q.filter_event;
	assign frame_timestamp = q.cap_ts;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	sequence s_hdr;
		wr_valid && wr_word == 5'h00 ##1 wr_valid && wr_word == 5'h01;
	endsequence
	sequence s_ovr_hold;
		(q.ovr && !q.lb && $stable(q.ovr_val))[*4];
	endsequence

	a_int_loop_tx: assert property (q.lb && q.mon |=> can_tx_pin) // [R4]
		else $error("tx pin not recessive in internal loop-back");
	a_loop_rx_src: assert property (q.lb |=> engine_rx == $past(engine_tx))
		else $error("loop-back rx not fed from tx"); // [R1]
	a_ack_mask: assert property (q.lb |=> !engine_ack_err) // [R2]
		else $error("ack error passed in loop-back");
	a_ovr_delay: assert property (s_ovr_hold |-> can_tx_pin == q.ovr_val)
		else $error("override value not on tx pin"); // [R5]
	a_ts_clear: assert property (ts_wr |=> q.ts == 16'h0000) // [R9]
		else $error("timestamp not cleared by write");
	a_ts_step: assert property (bit_tick && q.pc == q.timestamp_config_reg && !ts_wr
		|=> q.ts == 16'($past(q.ts) + 16'h0001)) // [R8]
		else $error("timestamp did not step");
	a_ts_wrap: assert property (bit_tick && q.pc == q.timestamp_config_reg && q.ts == 16'hFFFF
		&& !ts_wr |=> q.status[cantsf_pkg::ST_TSW]) // [R10]
		else $error("wrap flag not set");
	a_err_keep_nd: assert property (q.state == cantsf_pkg::S_DATA && frame_err
		&& !q.wr_pend |=> q.new_data == $past(q.new_data)) // [R14]
		else $error("new data changed on errored frame");
	a_err_keep_put: assert property (q.state == cantsf_pkg::S_DATA
		&& frame_err |=> $stable(q.put0) && $stable(q.put1)) // [R15]
		else $error("put index moved on errored frame");
	a_store_hdr: assert property (id_done && store |=> ##1 s_hdr) // [R13]
		else $error("store header words missing");
	a_id_kept: assert property (id_done && store
		|=> ##1 wr_data[28:0] == $past(rx_id, 2)) // [R16]
		else $error("stored id differs from received id");
	a_ts_capture: assert property (sof |=> q.cap_ts == $past(q.ts)) // [R11]
		else $error("timestamp not captured at frame start");
	a_passive_flag: assert property (err_passive != q.ep_prev
		|=> q.status[cantsf_pkg::ST_EP]) // [R22]
		else $error("passive change flag not set");
	a_nd_set: assert property (q.state == cantsf_pkg::S_DATA && frame_ok
		&& !frame_err && q.tgt == cantsf_pkg::TGT_BUF
		|=> q.new_data[$past(q.idx[4:0])]) // [R25]
		else $error("new data flag not set");
endmodule // cantsf_top

//--- tb/cantsf_bus_node.sv
// far-side bus node model: wired-and can line seen at the receive pin
`timescale 1ns/100ps
module cantsf_bus_node (
	// line driven by the block
	input wire logic can_tx_pin,
	// another node pulling the line dominant
	input wire logic node_dominant,
	// level seen back at the block
	output logic can_rx_pin
);
	// dominant 0 wins; a released line returns recessive through the bias
	assign can_rx_pin = can_tx_pin & ~node_dominant;
endmodule // cantsf_bus_node

//--- tb/testbench.sv
// self-checking bench of the can timestamp and filter block
`timescale 1ns/100ps
module testbench;
	logic sys_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, word_data, wr_data, rd;
	logic [1:0] htrans, wr_target;
	logic [2:0] hsize;
	logic can_rx_pin, can_tx_pin, engine_tx, engine_rx, ack_err;
	logic engine_ack_err, bit_tick, sof, id_done, rx_xtd, word_valid;
	logic frame_ok, frame_err, err_warning, err_passive, log_overflow;
	logic wr_valid, filter_event, node_dominant;
	logic [28:0] rx_id;
	logic [5:0] wr_index;
	logic [4:0] wr_word;
	logic [15:0] frame_timestamp;
	int n_errors = 0;
	int total_checks = 0;

	assign hready = hreadyout;
	cantsf_top #(.NUM_FILTERS(4), .PUT_W(6)) uut (.sys_clk, .reset_n,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .can_rx_pin, .can_tx_pin, .engine_tx,
		.engine_rx, .ack_err, .engine_ack_err, .bit_tick, .sof, .id_done,
		.rx_id, .rx_xtd, .word_valid, .word_data, .frame_ok, .frame_err,
		.err_warning, .err_passive, .log_overflow, .wr_valid, .wr_target,
		.wr_index, .wr_word, .wr_data, .filter_event, .frame_timestamp);
	cantsf_bus_node node (.can_tx_pin, .node_dominant, .can_rx_pin);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] e, input logic [31:0] a);
		total_checks++;
		if (a !== e) begin
			n_errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask

	task chk1(input logic e, input logic a);
		chk({31'h0, e}, {31'h0, a});
	endtask

	task clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// values read right after an edge are those that stood before it
	task wait_rdy;
		int n;
		n = 0;
		do begin
			clk(1);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			final_report;
		end
	endtask

	task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(a, 1'b1, d);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0);
		chk(e, rd);
	endtask

	task ticks(input int n);
		bit_tick <= 1'b1;
		clk(n);
		bit_tick <= 1'b0;
	endtask

	// one received frame; dst is target and index of the expected store
	task frame(input logic [28:0] id, input logic extended_id_flag, input logic ok,
			input logic hit, input logic [7:0] dst, input logic evt);
		int n;
		wr(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h0);
		ticks(2);
		sof <= 1'b1;
		clk(1);
		sof <= 1'b0;
		id_done <= 1'b1;
		rx_id <= id;
		rx_xtd <= extended_id_flag;
		clk(1);
		id_done <= 1'b0;
		n = 0;
		do begin
			clk(1);
			n++;
		end while (wr_valid !== 1'b1 && n < 5);
		chk1(hit, wr_valid);
		if (wr_valid === 1'b1) begin
			chk({2'h0, extended_id_flag, id}, wr_data);
			chk({19'h0, dst, 5'h0}, {19'h0, wr_target, wr_index, wr_word});
			clk(1);
			chk(32'h2, {16'h0, wr_data[15:0]});
			chk(32'h2, {16'h0, frame_timestamp});
			word_valid <= 1'b1;
			word_data <= 32'hC3A50F96;
			clk(1);
			word_valid <= 1'b0;
			clk(1);
			chk1(1'b1, wr_valid);
			chk(32'hC3A50F96, wr_data);
		end
		frame_ok <= ok;
		frame_err <= ~ok;
		clk(1);
		frame_ok <= 1'b0;
		frame_err <= 1'b0;
		clk(1);
		chk1(evt, filter_event);
	endtask

	task s_reset;
		rdchk(cantsf_pkg::ADDR_EXT_ID_AND_MASK, 32'h1FFFFFFF);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h0);
		rdchk(cantsf_pkg::ADDR_PUTIDX, 32'h0);
		wr(8'h30, 32'hFFFFFFFF);
		rdchk(8'h30, 32'h0);
		chk1(1'b0, hresp);
	endtask

	task s_status;
		err_warning <= 1'b1;
		err_passive <= 1'b1;
		log_overflow <= 1'b1;
		clk(1);
		log_overflow <= 1'b0;
		clk(2);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h01C00000);
		wr(cantsf_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h0);
	endtask

	task s_time;
		wr(cantsf_pkg::ADDR_TIMESTAMP_CONFIG_REG, 32'h0);
		wr(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h1234);
		ticks(3);
		rdchk(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h3);
		wr(cantsf_pkg::ADDR_TIMESTAMP_CONFIG_REG, 32'hF);
		wr(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h0);
		ticks(32);
		rdchk(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h2);
		wr(cantsf_pkg::ADDR_TIMESTAMP_CONFIG_REG, 32'h0);
		wr(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h0);
		ticks(65537);
		rdchk(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h1);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h1);
		wr(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h0);
		rdchk(cantsf_pkg::ADDR_TIMESTAMP_VALUE_REG, 32'h0);
		wr(cantsf_pkg::ADDR_STATUS, 32'h1);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h0);
	endtask

	// test modes used as a self test only
	task s_loop;
		int n;
		node_dominant <= 1'b1;
		ack_err <= 1'b1;
		clk(3);
		chk1(1'b0, engine_rx);
		chk1(1'b1, engine_ack_err);
		wr(cantsf_pkg::ADDR_TEST, 32'h1);
		clk(3);
		chk1(1'b1, engine_rx);
		chk1(1'b0, engine_ack_err);
		engine_tx <= 1'b0;
		clk(3);
		chk1(1'b0, engine_rx);
		chk1(1'b0, can_tx_pin);
		node_dominant <= 1'b0;
		wr(cantsf_pkg::ADDR_CONFIG, 32'h1);
		clk(3);
		chk1(1'b1, can_tx_pin);
		chk1(1'b0, engine_rx);
		chk1(1'b0, engine_ack_err);
		wr(cantsf_pkg::ADDR_CONFIG, 32'h0);
		wr(cantsf_pkg::ADDR_TEST, 32'h6);
		n = 0;
		do begin
			clk(1);
			n++;
		end while (can_tx_pin !== 1'b1 && n < 10);
		chk1(1'b1, can_tx_pin);
		clk(6);
		rdchk(cantsf_pkg::ADDR_TEST, 32'hE);
		node_dominant <= 1'b1;
		clk(6);
		rdchk(cantsf_pkg::ADDR_TEST, 32'h6);
		wr(cantsf_pkg::ADDR_TEST, 32'h0);
		engine_tx <= 1'b1;
		node_dominant <= 1'b0;
		ack_err <= 1'b0;
	endtask

	task s_filter;
		wr(8'h40, {3'h7, 29'h123});
		wr(8'h44, {3'h0, 29'h23});
		wr(8'h48, {3'h3, 29'h100});
		wr(8'h4C, {3'h2, 29'h700});
		wr(8'h50, {3'h1, 29'h1000});
		wr(8'h54, {3'h4, 29'h1FFF});
		wr(8'h58, {3'h6, 29'h55});
		wr(8'h5C, {3'h1, 29'h66});
		wr(cantsf_pkg::ADDR_EXT_ID_AND_MASK, 32'h0000FFFF);
		frame(29'h123, 1'b0, 1'b0, 1'b1, 8'h03, 1'b0);
		rdchk(cantsf_pkg::ADDR_NEWDATA, 32'h0);
		frame(29'h123, 1'b0, 1'b1, 1'b1, 8'h03, 1'b1);
		rdchk(cantsf_pkg::ADDR_NEWDATA, 32'h8);
		wr(cantsf_pkg::ADDR_NEWDATA, 32'h0);
		rdchk(cantsf_pkg::ADDR_NEWDATA, 32'h8);
		wr(cantsf_pkg::ADDR_NEWDATA, 32'h8);
		rdchk(cantsf_pkg::ADDR_NEWDATA, 32'h0);
		frame(29'h1AB, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		frame(29'h223, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		frame(29'h10001500, 1'b1, 1'b0, 1'b1, 8'h40, 1'b0);
		rdchk(cantsf_pkg::ADDR_PUTIDX, 32'h0);
		frame(29'h10001500, 1'b1, 1'b1, 1'b1, 8'h40, 1'b0);
		rdchk(cantsf_pkg::ADDR_PUTIDX, 32'h1);
		wr(8'h54, {3'h7, 29'h1FFF});
		frame(29'h10001500, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
		frame(29'h55, 1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
		frame(29'h66, 1'b0, 1'b1, 1'b1, 8'h80, 1'b0);
		frame(29'h55, 1'b0, 1'b1, 1'b1, 8'h81, 1'b0);
		rdchk(cantsf_pkg::ADDR_PUTIDX, 32'h201);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h2);
		wr(8'h4C, {3'h2, 29'h0});
		frame(29'h66, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		wr(cantsf_pkg::ADDR_STATUS, 32'h2);
		wr(8'h4C, {3'h2, 29'h700});
		wr(8'h58, {3'h4, 29'h55});
		frame(29'h55, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
		rdchk(cantsf_pkg::ADDR_STATUS, 32'h2);
		rdchk(cantsf_pkg::ADDR_PUTIDX, 32'h201);
	endtask

	initial begin
		reset_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		engine_tx = 1'b1;
		node_dominant = 1'b0;
		{ack_err, bit_tick, sof, id_done, rx_xtd, word_valid} = 6'h0;
		{frame_ok, frame_err, err_warning, err_passive, log_overflow} = 5'h0;
		rx_id = 29'h0;
		word_data = 32'h0;
		clk(8);
		reset_n <= 1'b1;
		clk(1);
		s_reset;
		s_status;
		s_time;
		s_loop;
		s_filter;
		final_report;
	end
endmodule // testbench
